// >>> hss_top.sv
/*
  hss_top: source selection for four high-side switches, supply fault
  shutdown and recovery, fault clearing, io pin functions, modulator A.
  Assumes a byte register port (addr, wdata, wr_en, rd_en) synchronous to
  ref_clk, fault and supply levels synchronous, and modulator B and timer
  signals supplied by neighbouring blocks.
*/
`timescale 1ns/1ps
`default_nettype none
module hss_top #(
  parameter int PWM_STEP_DIV = 2,
  parameter int FAIL_STEP_DIV = 2500
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // supply and per-switch faults
  input wire logic switch_supply_ov,
  input wire logic switch_supply_uv,
  input wire logic [3:0] switch_overcurrent,
  input wire logic [3:0] switch_overtemp,
  // cyclic timers and second modulator
  input wire logic cyclic_timer_a,
  input wire logic cyclic_timer_b,
  input wire logic [2:0] timer_a_on_code,
  input wire logic [2:0] timer_b_on_code,
  input wire logic duty_modulator_b,
  // fail outputs and io pins
  input wire logic fail_output_second,
  input wire logic fail_output_third_req,
  input wire logic hv_io_pin_first_in,
  input wire logic hv_io_pin_second_in,
  output logic [1:0] io_fail_drive,
  output logic [1:0] io_low_side_on,
  output logic [1:0] io_high_side_on,
  output logic [1:0] io_wake,
  // switch drive
  output logic [3:0] load_switch_on,
  output logic duty_modulator_a
);
  logic rst_s1, rst_n;
  logic [7:0] supply_fault_ctrl;
  logic [2:0] src [hss_pkg::NUM_SWITCH];
  logic [2:0] saved [hss_pkg::NUM_SWITCH];
  logic [7:0] io_pin_function_config;
  logic [7:0] modulator_a_duty;
  hss_pkg::hss_supply_t supply_state;
  logic shut_req, fault_gone;
  logic [15:0] pwm_div, fail_div;
  logic pwm_step, fail_step;
  logic [5:0] fail_phase;
  logic [5:0] fail_on;
  logic fail_output_third;
  // wide enough to hold the whole static filter count
  logic [7:0] wake_cnt [2];
  logic [1:0] wake_in;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  function automatic logic [7:0] pack_src(input logic [2:0] lo, input logic [2:0] hi);
    pack_src = {1'b0, hi, 1'b0, lo};
  endfunction

  function automatic logic timer_drive(input logic tmr, input logic [2:0] code);
    if (code == hss_pkg::TON_LOW) begin
      timer_drive = 1'b0;
    end else if (code == hss_pkg::TON_HIGH) begin
      timer_drive = 1'b1;
    end else begin
      timer_drive = tmr;
    end
  endfunction

  wire wr_fault = reg_wr_en && (reg_addr == hss_pkg::ADDR_SUPPLY_FAULT);
  wire wr_src_a = reg_wr_en && (reg_addr == hss_pkg::ADDR_SOURCE_A);
  wire wr_src_b = reg_wr_en && (reg_addr == hss_pkg::ADDR_SOURCE_B);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_fault_ctrl <= hss_pkg::RESET_VALUE;
    end else if (wr_fault) begin
      supply_fault_ctrl <= reg_wdata & hss_pkg::SUPPLY_FAULT_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_pin_function_config <= hss_pkg::RESET_VALUE;
      modulator_a_duty <= hss_pkg::RESET_VALUE;
    end else if (reg_wr_en && reg_addr == hss_pkg::ADDR_IO_CONFIG) begin
      io_pin_function_config <= reg_wdata;
    end else if (reg_wr_en && reg_addr == hss_pkg::ADDR_MOD_A_DUTY) begin
      modulator_a_duty <= reg_wdata;
    end
  end

  assign shut_req = (switch_supply_ov && !supply_fault_ctrl[hss_pkg::BIT_OV_DISABLE])
    || (switch_supply_uv && !supply_fault_ctrl[hss_pkg::BIT_UV_DISABLE]);
  assign fault_gone = !switch_supply_ov && !switch_supply_uv;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_state <= hss_pkg::HSS_SUPPLY_OK;
    end else begin
      case (supply_state)
        hss_pkg::HSS_SUPPLY_OK: begin
          if (shut_req) begin
            supply_state <= hss_pkg::HSS_SUPPLY_SHUT;
          end
        end
        hss_pkg::HSS_SUPPLY_SHUT: begin
          if (fault_gone) begin
            supply_state <= hss_pkg::HSS_SUPPLY_OK;
          end
        end
        default: supply_state <= hss_pkg::HSS_SUPPLY_OK;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < hss_pkg::NUM_SWITCH; g++) begin : g_sw
      localparam int LSB = (g % 2 == 0) ? hss_pkg::LO_FIELD : hss_pkg::HI_FIELD;
      wire wr_me = (g < 2) ? wr_src_a : wr_src_b;
      wire hw_clr = switch_overcurrent[g] || switch_overtemp[g];
      wire enter_shut = (supply_state == hss_pkg::HSS_SUPPLY_OK) && shut_req;
      wire leave_shut = (supply_state == hss_pkg::HSS_SUPPLY_SHUT) && fault_gone;
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          src[g] <= hss_pkg::SRC_OFF;
          saved[g] <= hss_pkg::SRC_OFF;
        end else if (hw_clr) begin
          src[g] <= hss_pkg::SRC_OFF;
          saved[g] <= hss_pkg::SRC_OFF;
        end else if (enter_shut) begin
          saved[g] <= src[g];
          src[g] <= hss_pkg::SRC_OFF;
        end else if (leave_shut && supply_fault_ctrl[hss_pkg::BIT_RECOVERY]) begin
          src[g] <= saved[g];
        end else if (wr_me && supply_state == hss_pkg::HSS_SUPPLY_OK) begin
          src[g] <= reg_wdata[LSB +: 3];
        end
      end
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          load_switch_on[g] <= 1'b0;
        end else begin
          case (src[g])
            hss_pkg::SRC_ON: load_switch_on[g] <= 1'b1;
            hss_pkg::SRC_TIMER_A: load_switch_on[g] <= timer_drive(cyclic_timer_a, timer_a_on_code);
            hss_pkg::SRC_TIMER_B: load_switch_on[g] <= timer_drive(cyclic_timer_b, timer_b_on_code);
            hss_pkg::SRC_MOD_A: load_switch_on[g] <= duty_modulator_a;
            hss_pkg::SRC_MOD_B: load_switch_on[g] <= duty_modulator_b;
            default: load_switch_on[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_div <= '0;
      fail_div <= '0;
    end else begin
      pwm_div <= (pwm_div == 16'(PWM_STEP_DIV - 1)) ? '0 : pwm_div + 16'h0001;
      fail_div <= (fail_div == 16'(FAIL_STEP_DIV - 1)) ? '0 : fail_div + 16'h0001;
    end
  end
  assign pwm_step = (pwm_div == 16'(PWM_STEP_DIV - 1));
  assign fail_step = (fail_div == 16'(FAIL_STEP_DIV - 1));

  hss_modulator #(.WIDTH(8)) u_mod_a (
    .clk(ref_clk),
    .rst_n(rst_n),
    .step_en(pwm_step),
    .duty(modulator_a_duty),
    .pwm(duty_modulator_a)
  );

  always_comb begin
    case (io_pin_function_config[hss_pkg::IO_DUTY_LSB +: 2])
      2'h0: fail_on = hss_pkg::FAIL_ON_20;
      2'h1: fail_on = hss_pkg::FAIL_ON_10;
      2'h2: fail_on = hss_pkg::FAIL_ON_5;
      default: fail_on = hss_pkg::FAIL_ON_2P5;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_phase <= '0;
    end else if (fail_step) begin
      fail_phase <= (fail_phase == hss_pkg::FAIL_WINDOW - 6'h01) ? '0 : fail_phase + 6'h01;
    end
  end
  // the third fail output blinks at the chosen duty only while requested
  assign fail_output_third = fail_output_third_req && (fail_phase < fail_on);

  assign wake_in = {hv_io_pin_second_in, hv_io_pin_first_in};

  generate
    for (g = 0; g < 2; g++) begin : g_io
      localparam int LSB = (g == 0) ? hss_pkg::IO_FIRST_LSB : hss_pkg::IO_SECOND_LSB;
      wire [2:0] code = io_pin_function_config[LSB +: 3];
      wire fail_src = (g == 0) ? fail_output_second : fail_output_third;
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          io_fail_drive[g] <= 1'b0;
          io_low_side_on[g] <= 1'b0;
          io_high_side_on[g] <= 1'b0;
        end else begin
          io_fail_drive[g] <= !code[2] && fail_src;
          io_low_side_on[g] <= (code == hss_pkg::IO_LOW_SIDE);
          io_high_side_on[g] <= (code == hss_pkg::IO_HIGH_SIDE);
        end
      end
      // static filter: the level must hold for the whole filter time to change
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          wake_cnt[g] <= '0;
          io_wake[g] <= 1'b0;
        end else if (code != hss_pkg::IO_WAKE || wake_in[g] == io_wake[g]) begin
          wake_cnt[g] <= '0;
          if (code != hss_pkg::IO_WAKE) begin
            io_wake[g] <= 1'b0;
          end
        end else if (wake_cnt[g] == 8'(hss_pkg::WAKE_FILTER_CYC - 1)) begin
          wake_cnt[g] <= '0;
          io_wake[g] <= wake_in[g];
        end else begin
          wake_cnt[g] <= wake_cnt[g] + 8'h01;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (reg_rd_en) begin
      reg_hit <= 1'b1;
      if (reg_addr == hss_pkg::ADDR_SUPPLY_FAULT) begin
        reg_rdata <= supply_fault_ctrl & hss_pkg::SUPPLY_FAULT_MASK;
      end else if (reg_addr == hss_pkg::ADDR_SOURCE_A) begin
        reg_rdata <= pack_src(src[0], src[1]);
      end else if (reg_addr == hss_pkg::ADDR_SOURCE_B) begin
        reg_rdata <= pack_src(src[2], src[3]);
      end else if (reg_addr == hss_pkg::ADDR_IO_CONFIG) begin
        reg_rdata <= io_pin_function_config;
      end else if (reg_addr == hss_pkg::ADDR_MOD_A_DUTY) begin
        reg_rdata <= modulator_a_duty;
      end else begin
        reg_rdata <= 8'h00;
        reg_hit <= 1'b0;
      end
    end else begin
      reg_hit <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> hss_pkg.sv
/*
  hss_pkg: register offsets, field layouts, reset values and codes for the
  high-side switch source control block.
  Assumes a byte-wide register port with 7-bit addresses decoded by the top.
*/
//
// Behaviour
// - overvoltage shutdown-disable bit 6 clear means supply overvoltage turns all switches off.
// - undervoltage shutdown-disable bit 5 clear means supply undervoltage turns switches off.
// - recovery bit 4 set restores prior switch states after the supply fault clears.
// - reserved bits in shutdown and switch registers always read as zero.
// - source codes: 000 off, 001 on, 010 timer A, 011 timer B, 110/111 reserved.
// - code 100 follows modulator A, 101 modulator B; switches 1,3 bits 2:0, 2,4 bits 6:4.
// - overcurrent or overtemperature clears that switch field so it is off and reads off.
// - second pin codes 000-011 route third fail output at duty 20,10,5,2.5 percent; the code routes it for all four and takes the duty from config bits 7:6.
// - code 100 turns pin off, 101 wake input with 16 us filter; first pin gets fail output.
// - code 110 drives pin as low-side switch, 111 as high-side switch.
// - modulator A duty 0 is always low, all ones always high, else value/255 on-time.
// - timer on-time code 000 holds switch low, code 110 holds it high.
package hss_pkg;
  localparam logic [6:0] ADDR_SUPPLY_FAULT = 7'h10;
  localparam logic [6:0] ADDR_SOURCE_A = 7'h14;
  localparam logic [6:0] ADDR_SOURCE_B = 7'h15;
  localparam logic [6:0] ADDR_IO_CONFIG = 7'h17;
  localparam logic [6:0] ADDR_MOD_A_DUTY = 7'h18;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] SUPPLY_FAULT_MASK = 8'h70;
  localparam logic [7:0] SOURCE_MASK = 8'h77;
  localparam int BIT_OV_DISABLE = 6;
  localparam int BIT_UV_DISABLE = 5;
  localparam int BIT_RECOVERY = 4;
  localparam int LO_FIELD = 0;
  localparam int HI_FIELD = 4;
  localparam int IO_FIRST_LSB = 0;
  localparam int IO_SECOND_LSB = 3;
  localparam int IO_DUTY_LSB = 6;
  localparam int NUM_SWITCH = 4;
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_ON = 3'h1;
  localparam logic [2:0] SRC_TIMER_A = 3'h2;
  localparam logic [2:0] SRC_TIMER_B = 3'h3;
  localparam logic [2:0] SRC_MOD_A = 3'h4;
  localparam logic [2:0] SRC_MOD_B = 3'h5;
  localparam logic [2:0] TON_LOW = 3'h0;
  localparam logic [2:0] TON_HIGH = 3'h6;
  localparam logic [2:0] IO_OFF = 3'h4;
  localparam logic [2:0] IO_WAKE = 3'h5;
  localparam logic [2:0] IO_LOW_SIDE = 3'h6;
  localparam logic [2:0] IO_HIGH_SIDE = 3'h7;
  // fail output duty: on-time per 40-step window, 20/10/5/2.5 percent
  localparam logic [5:0] FAIL_WINDOW = 6'd40;
  localparam logic [5:0] FAIL_ON_20 = 6'd8;
  localparam logic [5:0] FAIL_ON_10 = 6'd4;
  localparam logic [5:0] FAIL_ON_5 = 6'd2;
  localparam logic [5:0] FAIL_ON_2P5 = 6'd1;
  localparam logic [7:0] DUTY_MAX = 8'hff;
  localparam int WAKE_FILTER_NS = 16000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    HSS_SUPPLY_OK = 2'b00,
    HSS_SUPPLY_SHUT = 2'b01
  } hss_supply_t;
endpackage

// >>> hss_modulator.sv
/*
  hss_modulator: 8-bit duty modulator on a 255-step frame.
  Assumes step_en pulses once per duty step from a divider in the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module hss_modulator #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic step_en,
  input wire logic [WIDTH-1:0] duty,
  // output
  output logic pwm
);
  logic [WIDTH-1:0] phase;
  localparam logic [WIDTH-1:0] TOP = {WIDTH{1'b1}};

  // phase runs 0..254 so a duty of n is high for n of 255 steps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (step_en) begin
      phase <= (phase == TOP - 1'b1) ? '0 : phase + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm <= 1'b0;
    end else if (duty == TOP) begin
      pwm <= 1'b1;
    end else begin
      pwm <= (phase < duty);
    end
  end
endmodule
`default_nettype wire

// >>> hss_top_asserts.sv
/* hss_top_asserts: register readback and output behaviour checks for hss_top, bound into it.
   assumes only the host model writes the register port. */
`timescale 1ns/1ps
`default_nettype none
module hss_top_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  // faults
  input wire logic switch_supply_ov,
  input wire logic switch_supply_uv,
  input wire logic [3:0] switch_overcurrent,
  input wire logic [3:0] switch_overtemp,
  // outputs
  input wire logic [1:0] io_low_side_on,
  input wire logic [1:0] io_high_side_on,
  input wire logic [1:0] io_wake,
  input wire logic [3:0] load_switch_on,
  input wire logic duty_modulator_a
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  logic [7:0] sd, io, duty;
  logic [1:0] io_age, duty_age;
  // shadows track host writes; ages give registered outputs time to settle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sd <= 8'h00;
      io <= 8'h00;
      duty <= 8'h00;
      io_age <= 2'h0;
      duty_age <= 2'h0;
    end else begin
      if (reg_wr_en && reg_addr == 7'h10) sd <= reg_wdata;
      if (reg_wr_en && reg_addr == 7'h17) io <= reg_wdata;
      if (reg_wr_en && reg_addr == 7'h18) duty <= reg_wdata;
      io_age <= (reg_wr_en && reg_addr == 7'h17) ? 2'h0 : io_age + {1'b0, io_age != 2'h3};
      duty_age <= (reg_wr_en && reg_addr == 7'h18) ? 2'h0 : duty_age + {1'b0, duty_age != 2'h3};
    end
  end
  sd_reserved_a: assert property (reg_rd_en && reg_addr == 7'h10 |=> reg_hit &&
    reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0) else $error("shutdown reserved bits set");
  src_reserved_a: assert property (reg_rd_en && (reg_addr == 7'h14 || reg_addr == 7'h15)
    |=> reg_hit && (reg_rdata & 8'h88) == 8'h00) else $error("source reserved bits set");
  ov_shutdown_a: assert property (switch_supply_ov && !sd[6] |-> ##2 load_switch_on == 4'h0)
    else $error("switch on during overvoltage");
  uv_shutdown_a: assert property (switch_supply_uv && !sd[5] |-> ##2 load_switch_on == 4'h0)
    else $error("switch on during undervoltage");
  fault_clear_a: assert property ((switch_overcurrent | switch_overtemp) != 4'h0 |-> ##2
    (load_switch_on & $past(switch_overcurrent | switch_overtemp, 2)) == 4'h0)
    else $error("faulted switch still on");
  duty_limit_a: assert property (duty_age == 2'h3 && (duty == 8'h00 || duty == 8'hff)
    |-> duty_modulator_a == duty[0]) else $error("modulator not steady at limit duty");
  io_switch_a: assert property (io_age == 2'h3 |-> io_low_side_on == {io[5:3] == 3'h6,
    io[2:0] == 3'h6} && io_high_side_on == {io[5:3] == 3'h7, io[2:0] == 3'h7})
    else $error("pin switch state wrong");
  wake_off_a: assert property (io_age == 2'h3 && io[2:0] != 3'h5 |-> !io_wake[0])
    else $error("wake seen without wake code");
endmodule
bind hss_top hss_top_asserts chk_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
  .reg_hit(reg_hit), .switch_supply_ov(switch_supply_ov), .switch_supply_uv(switch_supply_uv),
  .switch_overcurrent(switch_overcurrent), .switch_overtemp(switch_overtemp),
  .io_low_side_on(io_low_side_on), .io_high_side_on(io_high_side_on), .io_wake(io_wake),
  .load_switch_on(load_switch_on), .duty_modulator_a(duty_modulator_a));
`default_nettype wire

// >>> hss_host_model.sv
/* hss_host_model: controller side of the byte register port.
   assumes clk is the design clock; tasks are called from tb. */
`timescale 1ns/1ps
`default_nettype none
module hss_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [6:0] addr,
  output logic [7:0] wdata,
  output logic wr_en,
  output logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic hit
);
  initial begin
    addr = 7'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // duty kept well above one count; no timer is tied to wake sensing
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic h);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
    h = hit;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
/* tb: scenario tests of hss_top through the host model.
   assumes a 10 MHz clock and shortened divider counts. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ov = 1'b0, uv = 1'b0, ta = 1'b0, tbt = 1'b0, mb = 1'b0, fo2 = 1'b1, fo3 = 1'b1;
  logic in1 = 1'b0;
  logic [3:0] oc = 4'h0, ot = 4'h0, lsw;
  logic [2:0] ton = 3'h1;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  logic wr, rd, hit, pa;
  logic [1:0] fdrv, lso, hso, wk;
  int failures = 0, num_checks = 0;
  always #50 ref_clk = ~ref_clk;
  hss_host_model host (.clk(ref_clk), .addr(addr), .wdata(wdata), .wr_en(wr), .rd_en(rd),
    .rdata(rdata), .hit(hit));
  hss_top #(.PWM_STEP_DIV(2), .FAIL_STEP_DIV(2)) dut_u (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr_en(wr), .reg_rd_en(rd), .reg_rdata(rdata),
    .reg_hit(hit), .switch_supply_ov(ov), .switch_supply_uv(uv), .switch_overcurrent(oc),
    .switch_overtemp(ot), .cyclic_timer_a(ta), .cyclic_timer_b(tbt), .timer_a_on_code(ton),
    .timer_b_on_code(ton), .duty_modulator_b(mb), .fail_output_second(fo2),
    .fail_output_third_req(fo3), .hv_io_pin_first_in(in1), .hv_io_pin_second_in(in1),
    .io_fail_drive(fdrv), .io_low_side_on(lso), .io_high_side_on(hso), .io_wake(wk),
    .load_switch_on(lsw), .duty_modulator_a(pa));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic h;
    host.rd(a, d, h);
    chk("rdata", {7'h0, h, d}, {8'h01, e});
  endtask
  task automatic src(input int g, input logic [2:0] c);
    host.wr(g < 2 ? 7'h14 : 7'h15, g[0] ? {1'b0, c, 4'h0} : {5'h00, c});
  endtask
  task automatic cnt(input int n, input bit p, output int c);
    c = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      c += p ? pa : fdrv[1];
    end
  endtask
  task automatic t_regs;
    logic [6:0] ad [5] = '{7'h10, 7'h14, 7'h15, 7'h17, 7'h18};
    logic [7:0] rb [5] = '{8'h70, 8'h77, 8'h77, 8'hff, 8'hff};
    logic [7:0] d;
    logic h;
    for (int i = 0; i < 5; i++) begin
      rc(ad[i], 8'h00);
      host.wr(ad[i], 8'hff);
      rc(ad[i], rb[i]);
      host.wr(ad[i], 8'h00);
    end
    host.rd(7'h20, d, h);
    chk("unmapped", {7'h0, h, d}, 16'h0000);
  endtask
  task automatic t_src;
    logic [5:0] e;
    for (int s = 0; s < 2; s++) begin
      e = s ? 6'b111010 : 6'b000110;
      @(posedge ref_clk);
      ta <= (s == 0);
      tbt <= (s == 1);
      mb <= (s == 1);
      host.wr(7'h18, s ? 8'hff : 8'h00);
      for (int g = 0; g < 4; g++) begin
        for (int c = 0; c < 6; c++) begin
          src(g, c[2:0]);
          cyc(3);
          chk("source", {15'h0, lsw[g]}, {15'h0, e[c]});
        end
      end
    end
    // switch 1 on timer A, switch 2 on timer B; both on-codes override the timers
    host.wr(7'h14, 8'h32);
    @(posedge ref_clk);
    ta <= 1'b1;
    tbt <= 1'b1;
    ton <= 3'h0;
    cyc(3);
    chk("timer low", {14'h0, lsw[1:0]}, 16'h0000);
    @(posedge ref_clk);
    ta <= 1'b0;
    tbt <= 1'b0;
    ton <= 3'h6;
    cyc(3);
    chk("timer high", {14'h0, lsw[1:0]}, 16'h0003);
    @(posedge ref_clk);
    ton <= 3'h1;
  endtask
  task automatic t_supply;
    logic [7:0] cfg [4] = '{8'h10, 8'h00, 8'h50, 8'h20};
    logic [2:0] ex [4] = '{3'b100, 3'b001, 3'b110, 3'b111};
    for (int k = 0; k < 4; k++) begin
      host.wr(7'h14, 8'h11);
      host.wr(7'h10, cfg[k]);
      @(posedge ref_clk);
      ov <= !ex[k][0];
      uv <= ex[k][0];
      cyc(4);
      chk("shutdown", {14'h0, lsw[1:0]}, {14'h0, {2{ex[k][1]}}});
      @(posedge ref_clk);
      ov <= 1'b0;
      uv <= 1'b0;
      cyc(4);
      chk("recovery", {14'h0, lsw[1:0]}, {14'h0, {2{ex[k][2]}}});
    end
  endtask
  task automatic t_fault;
    fork
      host.wr(7'h14, 8'h11);
      begin
        @(posedge ref_clk);
        oc <= 4'h1;
      end
    join
    cyc(2);
    @(posedge ref_clk);
    oc <= 4'h0;
    rc(7'h14, 8'h10);
    src(3, 3'h1);
    @(posedge ref_clk);
    ot <= 4'h8;
    cyc(3);
    // switch 2 keeps the on code written beside the faulted switch 1
    chk("overtemp", {12'h0, lsw}, 16'h0002);
    @(posedge ref_clk);
    ot <= 4'h0;
    rc(7'h15, 8'h00);
  endtask
  task automatic t_io;
    int n;
    for (int c = 0; c < 8; c++) begin
      host.wr(7'h17, {2'b00, c[2:0], c[2:0]});
      cyc(3);
      chk("pin", {9'h0, fdrv[0], lso, hso, wk},
        {9'h0, c < 4, {2{c == 6}}, {2{c == 7}}, 2'b00});
    end
    for (int d = 0; d < 4; d++) begin
      host.wr(7'h17, {d[1:0], 6'b000100});
      cyc(3);
      cnt(800, 1'b0, n);
      chk("fail duty", n[15:0], 16'd160 >> d);
    end
    host.wr(7'h17, 8'h2d);
    @(posedge ref_clk);
    in1 <= 1'b1;
    cyc(150);
    chk("wake early", {14'h0, wk}, 16'h0000);
    cyc(20);
    chk("wake late", {14'h0, wk}, 16'h0003);
  endtask
  task automatic t_pwm;
    int n;
    host.wr(7'h18, 8'h80);
    cnt(510, 1'b1, n);
    chk("duty half", n[15:0], 16'd256);
    host.wr(7'h18, 8'h03);
    cnt(510, 1'b1, n);
    chk("duty low", n[15:0], 16'd6);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    cyc(4);
    t_regs;
    t_src;
    t_supply;
    t_fault;
    t_io;
    t_pwm;
    final_report;
  end
  // bound well above the expected run of roughly 5000 cycles
  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
